// ---- core/rxo_pkg.sv ----
// Shared constants of the receiver audio output formatter.
// Assumes one core clock; both clock sources arrive as half-period tick pulses.
package rxo_pkg;

  // ****************************************
  // Register offsets and reset values
  // ****************************************
  localparam logic [7:0] RXO_ADDR_VDLY = 8'h22;
  localparam logic [7:0] RXO_ADDR_PAR  = 8'h23;
  localparam logic [7:0] RXO_ADDR_OSC  = 8'h24;
  localparam logic [7:0] RXO_ADDR_FMT  = 8'h2F;
  localparam logic [7:0] RXO_VDLY_RST  = 8'h00;
  localparam logic [7:0] RXO_PAR_RST   = 8'h00;
  localparam logic [7:0] RXO_OSC_RST   = 8'h00;
  localparam logic [7:0] RXO_FMT_RST   = 8'h04;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int RXO_VDLY_BIT    = 0;
  localparam int RXO_PAR_LSB     = 0;
  localparam int RXO_OSC_AUTO    = 0;
  localparam int RXO_COPY_EN     = 1;
  localparam int RXO_COPY_DIV    = 2;
  localparam int RXO_SRC_REF     = 4;
  localparam int RXO_OSC_RUN_BIT = 7;
  localparam int RXO_FMT_LSB     = 0;

  // ****************************************
  // Encodings and counts
  // ****************************************
  localparam logic [2:0] RXO_FMT_RJ24  = 3'h0;
  localparam logic [2:0] RXO_FMT_RJ16  = 3'h3;
  localparam logic [2:0] RXO_FMT_I2S   = 3'h4;
  localparam logic [2:0] RXO_FMT_LJ24  = 3'h5;
  localparam logic [1:0] RXO_POL_OFF   = 2'h0;
  localparam logic [1:0] RXO_POL_PCM   = 2'h1;
  localparam logic [1:0] RXO_POL_ALL   = 2'h2;
  localparam logic [3:0] RXO_ERR_LIMIT = 4'h8;
  localparam logic [3:0] RXO_BFR_LEN   = 4'h8;
  localparam logic [7:0] RXO_FRAME_MAX = 8'hBF;
  localparam logic [7:0] RXO_NPCM_FRM  = 8'h01;
  localparam int         RXO_SMP_W     = 24;
  localparam int         RXO_FIFO_D    = 4;

  // ****************************************
  // Layout of one queued frame
  // ****************************************
  localparam int RXO_FW    = 55;
  localparam int RXO_W_BLK = 54;
  localparam int RXO_W_VL  = 53;
  localparam int RXO_W_VR  = 52;
  localparam int RXO_W_CL  = 51;
  localparam int RXO_W_UL  = 50;
  localparam int RXO_W_CR  = 49;
  localparam int RXO_W_UR  = 48;
  localparam int RXO_W_L   = 24;
  localparam int RXO_W_R   = 0;

endpackage

// ---- core/rxo_formatter.sv ----
// Receiver audio output formatter: error policy, frame queue, serial output and clocks.
// Assumes decoded subframes arrive from the biphase decoder with a valid/ready handshake
// and that the recovered and reference clocks arrive as one-cycle half-period ticks.
//
// What this block does
// - In reference source mode, all output clocks come from the reference clock.
// - Auto-off bit stops the reference oscillator while it is not needed.
// - Reference oscillator stays on in wide mode or while the rate calculator runs.
// - Buffered divided reference copy output, with enable bit and divider field.
// - Audio words go out most significant bit first, two's complement.
// - Format field selects right-justified 24/16, I2S default, or left-justified.
// - Audio and frame clock leave a few sample periods after input data.
// - Bit clock is 64 fs; data and frame clock change on its fall.
// - Channel status, user and validity bits each have their own output.
// - Frame clock polarity follows the selected output format.
// - Block-start flag stays high for eight frame clock periods.
// - Per-frame outputs follow frame numbers zero through 191 within a block.
// - Validity delay bit picks immediate or frame-aligned validity output.
// - Under policy 01 or 10, a PCM sample with an error is replaced by its channel's last good sample until muted.
// - Non-PCM data, channel status bit one set, passes through unchanged except under policy 10.
// - Policy 01 repeats last good PCM sample, mutes after eight errors.
// - Policy 10 repeats then mutes for both PCM and non-PCM data.
// - Policy 00 ignores parity errors and passes data unchanged.
`timescale 1ns/10ps

// ****************************************
// Frame queue
// ****************************************
module rxo_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         CORE_CLK_I,
  input  wire logic         RESET_I,
  input  wire logic         IN_VALID_I,
  output logic              IN_READY_O,
  input  wire logic [W-1:0] IN_DATA_I,
  output logic              OUT_VALID_O,
  input  wire logic         OUT_READY_I,
  output logic [W-1:0]      OUT_DATA_O
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } rxo_fifo_st_t;
  rxo_fifo_st_t q, d;
  logic push, pop;

  assign IN_READY_O  = q.cnt != (AW+1)'(D);
  assign OUT_VALID_O = q.cnt != '0;
  assign OUT_DATA_O  = q.mem[q.rp];
  assign push        = IN_VALID_I && IN_READY_O;
  assign pop         = OUT_VALID_O && OUT_READY_I;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = IN_DATA_I;
      d.wp        = (q.wp == AW'(D-1)) ? '0 : q.wp + AW'(1);
    end
    if (pop) begin
      d.rp = (q.rp == AW'(D-1)) ? '0 : q.rp + AW'(1);
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // rxo_fifo

// ****************************************
// Output formatter
// ****************************************
module rxo_formatter (
  input  wire logic                        CORE_CLK_I,
  input  wire logic                        RESET_I,
  input  wire logic                        REG_WR_I,
  input  wire logic                        REG_RD_I,
  input  wire logic [7:0]                  REG_ADDR_I,
  input  wire logic [7:0]                  REG_WDATA_I,
  output logic      [7:0]                  REG_RDATA_O,
  input  wire logic                        SUB_VALID_I,
  output logic                             SUB_READY_O,
  input  wire logic                        SUB_CHAN_I,
  input  wire logic [rxo_pkg::RXO_SMP_W-1:0] SAMPLE_I,
  input  wire logic                        PARITY_ERR_I,
  input  wire logic                        C_BIT_I,
  input  wire logic                        U_BIT_I,
  input  wire logic                        V_BIT_I,
  input  wire logic                        BLOCK_START_I,
  input  wire logic                        PLL_TICK_I,
  input  wire logic                        REF_TICK_I,
  input  wire logic                        WIDE_MODE_I,
  input  wire logic                        FS_CALC_ACTIVE_I,
  output logic                             SYS_CLOCK_OUT_O,
  output logic                             BIT_CLOCK_OUT_O,
  output logic                             FRAME_CLOCK_OUT_O,
  output logic                             SERIAL_DATA_O,
  output logic                             CHANNEL_STATUS_OUT_O,
  output logic                             USER_BITS_OUT_O,
  output logic                             VALIDITY_OUT_O,
  output logic                             BLOCK_START_FLAG_O,
  output logic                             REF_CLOCK_COPY_OUT_O,
  output logic                             REF_OSC_RUN_O
);
  import rxo_pkg::*;

  typedef struct packed {
    logic [7:0]            vdly;
    logic [7:0]            par;
    logic [7:0]            osc;
    logic [7:0]            fmt;
    logic [7:0]            rdata;
    logic [7:0]            cnt;
    logic [2:0]            div_cnt;
    logic                  copy;
    logic [RXO_SMP_W-1:0]  sl;
    logic                  cl;
    logic                  ul;
    logic                  vl;
    logic                  blk;
    logic [7:0]            frame_no;
    logic                  npcm;
    logic [RXO_SMP_W-1:0]  good_l;
    logic [RXO_SMP_W-1:0]  good_r;
    logic [3:0]            err_cnt;
    logic                  mute;
    logic [RXO_FW-1:0]     ofr;
    logic [3:0]            bfr_cnt;
    logic                  sck;
    logic                  bck;
    logic                  lrck;
    logic                  sdata;
    logic                  channel_status_out;
    logic                  user_bits_out;
    logic                  validity_out;
  } rxo_st_t;
  rxo_st_t q, d;

  // Bit of the current half-frame word for slot s; unknown codes fall back to I2S
  function automatic logic fmt_bit(input logic [2:0] f, input logic [23:0] w,
                                   input logic [4:0] s);
    logic [4:0] first;
    logic [4:0] last;
    logic [4:0] idx;
    first = 5'h01;
    last  = 5'h18;
    case (f)
      RXO_FMT_RJ24: begin
        first = 5'h08;
        last  = 5'h1F;
      end
      RXO_FMT_RJ16: begin
        first = 5'h10;
        last  = 5'h1F;
      end
      RXO_FMT_LJ24: begin
        first = 5'h00;
        last  = 5'h17;
      end
      default: begin
        first = 5'h01;
        last  = 5'h18;
      end
    endcase
    idx = s - first;
    if (s >= first && s <= last) begin
      fmt_bit = w[5'h17 - idx];
    end else begin
      fmt_bit = 1'b0;
    end
  endfunction

  logic                 tick, acc, src_ref, pol_active, rep_mute, osc_run;
  logic                 push_v, pop_v, pop_r;
  logic [RXO_FW-1:0]    push_w, pop_w, wsel;
  logic [RXO_SMP_W-1:0] ch_good, proc;
  logic [7:0]           n;
  logic [2:0]           div_end;

  // ****************************************
  // Clock source, error policy and queue
  // ****************************************
  assign src_ref    = q.osc[RXO_SRC_REF];
  assign tick       = src_ref ? REF_TICK_I : PLL_TICK_I;
  assign osc_run    = !(q.osc[RXO_OSC_AUTO] && !src_ref && !WIDE_MODE_I
                        && !FS_CALC_ACTIVE_I);
  assign acc        = SUB_VALID_I && SUB_READY_O;
  assign pol_active = (q.par[1:0] == RXO_POL_PCM && !q.npcm)
                      || q.par[1:0] == RXO_POL_ALL;
  assign rep_mute   = q.mute || q.err_cnt >= RXO_ERR_LIMIT;
  assign ch_good    = SUB_CHAN_I ? q.good_r : q.good_l;
  assign proc       = (!PARITY_ERR_I || !pol_active) ? SAMPLE_I
                      : (rep_mute ? '0 : ch_good);
  assign push_v     = SUB_VALID_I && SUB_CHAN_I;
  assign push_w     = {q.blk, q.vl, V_BIT_I, q.cl, q.ul, C_BIT_I, U_BIT_I, q.sl, proc};
  assign n          = q.cnt + 8'h01;
  assign pop_r      = tick && n == 8'h00;
  assign wsel       = (pop_v && n == 8'h00) ? pop_w : q.ofr;
  assign div_end    = 3'((4'h1 << q.osc[RXO_COPY_DIV +: 2]) - 4'h1);

  // Queue depth sets the typical latency from decoded subframe to output
  rxo_fifo #(
    .W (RXO_FW),
    .D (RXO_FIFO_D)
  ) u_fifo (
    .CORE_CLK_I  (CORE_CLK_I),
    .RESET_I     (RESET_I),
    .IN_VALID_I  (push_v),
    .IN_READY_O  (SUB_READY_O),
    .IN_DATA_I   (push_w),
    .OUT_VALID_O (pop_v),
    .OUT_READY_I (pop_r),
    .OUT_DATA_O  (pop_w)
  );

  always_comb begin
    d = q;
    // ****************************************
    // Registers
    // ****************************************
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        RXO_ADDR_VDLY: d.vdly = REG_WDATA_I;
        RXO_ADDR_PAR:  d.par  = REG_WDATA_I;
        RXO_ADDR_OSC:  d.osc  = REG_WDATA_I;
        RXO_ADDR_FMT:  d.fmt  = REG_WDATA_I;
        default:       d.par  = q.par;
      endcase
    end
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        RXO_ADDR_VDLY: d.rdata = q.vdly;
        RXO_ADDR_PAR:  d.rdata = q.par;
        RXO_ADDR_OSC:  d.rdata = {osc_run, q.osc[6:0]};
        RXO_ADDR_FMT:  d.rdata = q.fmt;
        default:       d.rdata = 8'h00;
      endcase
    end
    // ****************************************
    // Incoming subframes
    // ****************************************
    if (acc) begin
      if (!SUB_CHAN_I) begin
        d.sl  = proc;
        d.cl  = C_BIT_I;
        d.ul  = U_BIT_I;
        d.vl  = V_BIT_I;
        d.blk = BLOCK_START_I;
        if (BLOCK_START_I || q.frame_no == RXO_FRAME_MAX) begin
          d.frame_no = 8'h00;
        end else begin
          d.frame_no = q.frame_no + 8'h01;
        end
        if (d.frame_no == RXO_NPCM_FRM) begin
          d.npcm = C_BIT_I;
        end
      end
      if (!PARITY_ERR_I) begin
        if (SUB_CHAN_I) begin
          d.good_r = SAMPLE_I;
        end else begin
          d.good_l = SAMPLE_I;
        end
        d.err_cnt = 4'h0;
        d.mute    = 1'b0;
      end else if (pol_active) begin
        if (q.err_cnt < RXO_ERR_LIMIT) begin
          d.err_cnt = q.err_cnt + 4'h1;
        end
        if (rep_mute) begin
          d.mute = 1'b1;
        end
      end
      if (!q.vdly[RXO_VDLY_BIT]) begin
        d.validity_out = V_BIT_I;
      end
    end
    // ****************************************
    // Output clocks and serial stream
    // ****************************************
    if (tick) begin
      d.cnt = n;
      d.sck = n[0];
      d.bck = n[1];
      if (n[1:0] == 2'h0) begin
        d.ofr   = wsel;
        d.lrck  = (q.fmt[2:0] == RXO_FMT_I2S) ? n[7] : !n[7];
        d.sdata = fmt_bit(q.fmt[2:0], n[7] ? wsel[RXO_W_R +: RXO_SMP_W]
                          : wsel[RXO_W_L +: RXO_SMP_W], n[6:2]);
        if (n[6:2] == 5'h00) begin
          d.channel_status_out = n[7] ? wsel[RXO_W_CR] : wsel[RXO_W_CL];
          d.user_bits_out = n[7] ? wsel[RXO_W_UR] : wsel[RXO_W_UL];
          if (q.vdly[RXO_VDLY_BIT]) begin
            d.validity_out = n[7] ? wsel[RXO_W_VR] : wsel[RXO_W_VL];
          end
        end
      end
      if (n == 8'h00) begin
        if (pop_v && pop_w[RXO_W_BLK]) begin
          d.bfr_cnt = RXO_BFR_LEN;
        end else if (q.bfr_cnt != 4'h0) begin
          d.bfr_cnt = q.bfr_cnt - 4'h1;
        end
      end
    end
    // ****************************************
    // Divided reference copy
    // ****************************************
    if (!q.osc[RXO_COPY_EN] || !osc_run) begin
      d.copy    = 1'b0;
      d.div_cnt = 3'h0;
    end else if (REF_TICK_I) begin
      if (q.div_cnt >= div_end) begin
        d.div_cnt = 3'h0;
        d.copy    = !q.copy;
      end else begin
        d.div_cnt = q.div_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      q      <= '0;
      q.vdly <= RXO_VDLY_RST;
      q.par  <= RXO_PAR_RST;
      q.osc  <= RXO_OSC_RST;
      q.fmt  <= RXO_FMT_RST;
    end else begin
      q <= d;
    end
  end

  assign REG_RDATA_O          = q.rdata;
  assign SYS_CLOCK_OUT_O      = q.sck;
  assign BIT_CLOCK_OUT_O      = q.bck;
  assign FRAME_CLOCK_OUT_O    = q.lrck;
  assign SERIAL_DATA_O        = q.sdata;
  assign CHANNEL_STATUS_OUT_O = q.channel_status_out;
  assign USER_BITS_OUT_O      = q.user_bits_out;
  assign VALIDITY_OUT_O       = q.validity_out;
  assign BLOCK_START_FLAG_O   = q.bfr_cnt != 4'h0;
  assign REF_CLOCK_COPY_OUT_O = q.copy;
  assign REF_OSC_RUN_O        = osc_run;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);

  a_bfr_length: assert property ($rose(BLOCK_START_FLAG_O) |-> q.bfr_cnt == 4'h8)
    else $error("block flag not loaded with eight frames");
  a_fmt_default: assert property ($past(RESET_I) |-> q.fmt[2:0] == RXO_FMT_I2S)
    else $error("format not I2S after reset");
  a_data_on_fall: assert property ($changed(SERIAL_DATA_O) |-> $fell(BIT_CLOCK_OUT_O))
    else $error("serial data moved off the bit clock fall");
  a_lrck_on_fall: assert property ($changed(FRAME_CLOCK_OUT_O) |-> $fell(BIT_CLOCK_OUT_O))
    else $error("frame clock moved off the bit clock fall");
  a_osc_wide_kept: assert property (WIDE_MODE_I || FS_CALC_ACTIVE_I |-> REF_OSC_RUN_O)
    else $error("reference oscillator stopped while needed");
  a_osc_auto_off: assert property (q.osc[0] && !q.osc[4] && !WIDE_MODE_I && !FS_CALC_ACTIVE_I
                                   |-> !REF_OSC_RUN_O)
    else $error("reference oscillator running while unneeded");
  a_mute_after_eight: assert property (acc && PARITY_ERR_I && pol_active
                                       && q.err_cnt == 4'h8 |=> q.mute)
    else $error("no mute after eight consecutive errors");
  a_ignore_parity: assert property (acc && !SUB_CHAN_I && q.par[1:0] == RXO_POL_OFF
                                    |=> q.sl == $past(SAMPLE_I))
    else $error("sample altered with parity policy off");
  a_copy_muted: assert property (!q.osc[1] |=> !REF_CLOCK_COPY_OUT_O)
    else $error("reference copy running while disabled");
  a_frame_range: assert property (q.frame_no <= RXO_FRAME_MAX)
    else $error("frame number past last frame of block");
  a_tick_source: assert property (!tick |=> $stable(q.cnt))
    else $error("output clocks advanced without a source tick");
endmodule // rxo_formatter

// ---- verification/rxo_dsp_model.sv ----
// DSP-side receiver model: shifts serial audio in on bit clock rises.
// Assumes bit and frame clocks are registered outputs, slow against the core clock.
`timescale 1ns/10ps
module rxo_dsp_model (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        BIT_CLOCK_I,
  input  wire logic        FRAME_CLOCK_I,
  input  wire logic        SERIAL_DATA_I,
  output logic [31:0]      WORD_LOW_O,
  output logic [31:0]      WORD_HIGH_O,
  output logic             SHORT_HALF_O
);
  logic        bck_q;
  logic        lrck_q;
  logic [31:0] shift_q;
  logic [6:0]  count_q;

  // A half is published only when exactly 32 bits preceded the frame clock change
  always_ff @(posedge CORE_CLK_I) begin
    bck_q <= BIT_CLOCK_I;
    if (RESET_I) begin
      lrck_q       <= 1'b0;
      count_q      <= 7'h00;
      WORD_LOW_O   <= 32'h00000000;
      WORD_HIGH_O  <= 32'h00000000;
      SHORT_HALF_O <= 1'b0;
    end else if (BIT_CLOCK_I && !bck_q) begin
      lrck_q  <= FRAME_CLOCK_I;
      shift_q <= {shift_q[30:0], SERIAL_DATA_I};
      count_q <= (count_q == 7'h7F) ? count_q : count_q + 7'h01;
      if (FRAME_CLOCK_I != lrck_q) begin
        count_q <= 7'h01;
        if (count_q == 7'h20 && lrck_q) WORD_HIGH_O <= shift_q;
        if (count_q == 7'h20 && !lrck_q) WORD_LOW_O <= shift_q;
        if (count_q != 7'h00 && count_q < 7'h20) SHORT_HALF_O <= 1'b1;
      end
    end
  end
endmodule  // rxo_dsp_model

// ---- verification/rxo_formatter_bench.sv ----
// Self-checking bench of the output formatter with a DSP-side receiver model.
// Assumes source ticks every other core cycle and an idle queue between frames.
`timescale 1ns/10ps
module rxo_formatter_bench;
  import rxo_pkg::*;
  typedef struct {
    logic [2:0]  fmt;
    logic [23:0] l;
    logic [23:0] r;
    logic [2:0]  cuv;
    logic [31:0] el;
    logic [31:0] er;
  } rxo_row_t;
  logic        core_clk, reset, reg_wr, reg_rd, sub_valid, sub_chan, perr;
  logic        c_bit, u_bit, v_bit, blk, pll_tick, ref_tick, wide, calc;
  logic        use_ref, left_low, sub_ready, sck, bck, lrck, sdata;
  logic        c_out, u_out, v_out, bflag, copy, osc_run, short_half;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [23:0] sample;
  logic [31:0] w_lo, w_hi, got_l, got_r;
  logic [2:0]  cuv_l, cuv_r;
  logic [10:0] osc_set [5] = '{11'h400, 11'h001, 11'h501, 11'h601, 11'h411};
  logic [7:0]  rst_adr [5] = '{RXO_ADDR_FMT, RXO_ADDR_VDLY, RXO_ADDR_PAR, RXO_ADDR_OSC, 8'h30};
  logic [7:0]  rst_val [5] = '{8'h04, 8'h00, 8'h00, 8'h80, 8'h00};
  int          num_errors, check_count, bck_edges, sck_edges, copy_edges, flag_ticks;
  rxo_row_t    rows [4] = '{
    '{RXO_FMT_I2S, 24'h812345, 24'h7EDCBA, 3'h5, 32'h4091A280, 32'h3F6E5D00},
    '{RXO_FMT_LJ24, 24'hA5F00F, 24'h0FF0A5, 3'h2, 32'hA5F00F00, 32'h0FF0A500},
    '{RXO_FMT_RJ24, 24'h123456, 24'hFEDCBA, 3'h6, 32'h00123456, 32'h00FEDCBA},
    '{RXO_FMT_RJ16, 24'h8000FF, 24'h7FFF00, 3'h1, 32'h00008000, 32'h00007FFF}};

  assign got_l = left_low ? w_lo : w_hi;
  assign got_r = left_low ? w_hi : w_lo;

  rxo_formatter u_rxo_formatter (
    .CORE_CLK_I(core_clk), .RESET_I(reset), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
    .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_RDATA_O(reg_rdata),
    .SUB_VALID_I(sub_valid), .SUB_READY_O(sub_ready), .SUB_CHAN_I(sub_chan),
    .SAMPLE_I(sample), .PARITY_ERR_I(perr), .C_BIT_I(c_bit), .U_BIT_I(u_bit),
    .V_BIT_I(v_bit), .BLOCK_START_I(blk), .PLL_TICK_I(pll_tick), .REF_TICK_I(ref_tick),
    .WIDE_MODE_I(wide), .FS_CALC_ACTIVE_I(calc), .SYS_CLOCK_OUT_O(sck),
    .BIT_CLOCK_OUT_O(bck), .FRAME_CLOCK_OUT_O(lrck), .SERIAL_DATA_O(sdata),
    .CHANNEL_STATUS_OUT_O(c_out), .USER_BITS_OUT_O(u_out), .VALIDITY_OUT_O(v_out),
    .BLOCK_START_FLAG_O(bflag), .REF_CLOCK_COPY_OUT_O(copy), .REF_OSC_RUN_O(osc_run));

  rxo_dsp_model u_rxo_dsp_model (
    .CORE_CLK_I(core_clk), .RESET_I(reset), .BIT_CLOCK_I(bck), .FRAME_CLOCK_I(lrck),
    .SERIAL_DATA_I(sdata), .WORD_LOW_O(w_lo), .WORD_HIGH_O(w_hi), .SHORT_HALF_O(short_half));

  // ****************************************
  // Clock, edge counters and tasks
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Edges are counted as they happen, so a change on the last tick is seen at once
  always @(bck) bck_edges++;
  always @(sck) sck_edges++;
  always @(copy) copy_edges++;

  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a);
    @(posedge core_clk);
    #1;
    {reg_rd, reg_addr} = {1'b1, a};
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    rd_val = reg_rdata;
  endtask

  // Each tick is a one-cycle pulse; the reference tick stands for the 24.576 MHz input
  task automatic run_ticks(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (bflag === 1'b1) flag_ticks++;
      pll_tick = !use_ref;
      ref_tick = use_ref;
      @(posedge core_clk);
      #1;
      pll_tick = 1'b0;
      ref_tick = 1'b0;
    end
  endtask

  task automatic push_sub(input logic ch, input logic [23:0] s, input logic e,
                          input logic [2:0] cuv, input logic b);
    int k;
    k = 0;
    @(posedge core_clk);
    #1;
    {sub_valid, sub_chan, sample, perr, c_bit, u_bit, v_bit, blk} = {1'b1, ch, s, e, cuv, b};
    while (sub_ready !== 1'b1 && k < 50) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (k == 50) num_errors++;
    @(posedge core_clk);
    #1;
    sub_valid = 1'b0;
  endtask

  task automatic push_frame(input logic [23:0] l, input logic [23:0] r, input logic e,
                            input logic b, input logic [2:0] cl, input logic [2:0] cr);
    push_sub(1'b0, l, e, cl, b);
    push_sub(1'b1, r, e, cr, 1'b0);
  endtask

  // Three frames; captures fall in a left and a right half from count 0 or 127
  task automatic play();
    run_ticks(512);
    cuv_l = {c_out, u_out, v_out};
    run_ticks(128);
    cuv_r = {c_out, u_out, v_out};
    run_ticks(128);
  endtask

  function automatic logic [31:0] i2s(input logic [23:0] s);
    return {1'b0, s, 7'h00};
  endfunction

  initial begin
    #5000000;
    num_errors++;
    close_out();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {reg_wr, reg_rd, sub_valid, sub_chan, perr, c_bit, u_bit, v_bit, blk} = 9'h000;
    {pll_tick, ref_tick, wide, calc, use_ref, left_low} = 6'h01;
    {reg_addr, reg_wdata, sample} = 40'h0000000000;
    {num_errors, check_count, bck_edges, sck_edges, copy_edges, flag_ticks} = '0;
    reset = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    reset = 1'b0;
    reg_write(RXO_ADDR_VDLY, 8'h01);
    // Format writes land just before a half boundary, so a polarity flip never cuts a half
    run_ticks(127);
    {bck_edges, sck_edges} = '0;
    foreach (rows[i]) begin
      reg_write(RXO_ADDR_FMT, {5'h00, rows[i].fmt});
      left_low = (rows[i].fmt == RXO_FMT_I2S);
      push_frame(rows[i].l, rows[i].r, 1'b0, 1'b0, rows[i].cuv, 3'(~rows[i].cuv));
      play();
      check_val("left word", rows[i].el, got_l);
      check_val("right word", rows[i].er, got_r);
      check_val("left status", 32'(rows[i].cuv), 32'(cuv_l));
      check_val("right status", 32'(3'(~rows[i].cuv)), 32'(cuv_r));
    end
    check_bit("short half", 1'b0, short_half);
    check_val("sck edges", 32'(2 * bck_edges), 32'(sck_edges));
    reset = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    reset = 1'b0;
    left_low = 1'b1;
    reg_write(8'h30, 8'hFF);
    foreach (rst_adr[i]) begin
      reg_read(rst_adr[i]);
      check_val("reset value", 32'(rst_val[i]), 32'(rd_val));
    end
    foreach (osc_set[i]) begin
      reg_write(RXO_ADDR_OSC, osc_set[i][7:0]);
      {calc, wide} = osc_set[i][9:8];
      reg_read(RXO_ADDR_OSC);
      check_bit("osc run", osc_set[i][10], osc_run);
      check_val("osc reg", 32'({osc_set[i][10], osc_set[i][6:0]}), 32'(rd_val));
    end
    {calc, wide} = 2'h0;
    bck_edges = 0;
    run_ticks(32);
    check_val("bck on pll ticks", 32'h0, 32'(bck_edges));
    use_ref = 1'b1;
    run_ticks(256);
    check_val("bck on ref ticks", 32'h80, 32'(bck_edges));
    for (int d = 0; d < 5; d++) begin
      reg_write(RXO_ADDR_OSC, (d < 4) ? {4'h0, 2'(d), 2'h2} : 8'h00);
      copy_edges = 0;
      run_ticks(64);
      check_val("copy toggles", (d < 4) ? 32'(64 >> d) : 32'h0, 32'(copy_edges));
    end
    use_ref = 1'b0;
    reg_write(RXO_ADDR_PAR, {6'h00, RXO_POL_PCM});
    push_frame(24'h111111, 24'h222222, 1'b0, 1'b0, 3'h0, 3'h0);
    play();
    for (int k = 1; k <= 9; k++) begin
      push_frame(24'h333333, 24'h444444, 1'b1, 1'b0, 3'h0, 3'h0);
      bck_edges = 0;
      play();
      if (k <= 4) check_val("repeat left", i2s(24'h111111), got_l);
      if (k <= 4) check_val("repeat right", i2s(24'h222222), got_r);
    end
    check_val("mute left", 32'h0, got_l);
    check_val("mute right", 32'h0, got_r);
    check_val("clocks in mute", 32'h180, 32'(bck_edges));
    push_frame(24'h555555, 24'h666666, 1'b0, 1'b0, 3'h0, 3'h0);
    play();
    check_val("unmuted", i2s(24'h555555), got_l);
    reg_write(RXO_ADDR_PAR, {6'h00, RXO_POL_OFF});
    push_frame(24'h777777, 24'h888888, 1'b1, 1'b0, 3'h0, 3'h0);
    play();
    check_val("ignored error", i2s(24'h888888), got_r);
    reg_write(RXO_ADDR_PAR, {6'h00, RXO_POL_PCM});
    flag_ticks = 0;
    push_frame(24'h0A0A0A, 24'h0B0B0B, 1'b0, 1'b1, 3'h0, 3'h0);
    play();
    push_frame(24'h0C0C0C, 24'h0D0D0D, 1'b0, 1'b0, 3'h4, 3'h0);
    play();
    push_frame(24'h0E0E0E, 24'h0F0F0F, 1'b1, 1'b0, 3'h0, 3'h0);
    play();
    check_val("coded pass", i2s(24'h0E0E0E), got_l);
    push_frame(24'h141414, 24'h151515, 1'b0, 1'b0, 3'h0, 3'h0);
    play();
    reg_write(RXO_ADDR_PAR, {6'h00, RXO_POL_ALL});
    push_frame(24'h121212, 24'h131313, 1'b1, 1'b0, 3'h0, 3'h0);
    play();
    check_val("coded repeat", i2s(24'h141414), got_l);
    check_val("block flag ticks", 32'd2048, 32'(flag_ticks));
    reg_write(RXO_ADDR_VDLY, 8'h01);
    push_frame(24'h010101, 24'h020202, 1'b0, 1'b0, 3'h0, 3'h0);
    play();
    push_sub(1'b0, 24'h030303, 1'b0, 3'h1, 1'b0);
    #150;
    check_bit("validity held", 1'b0, v_out);
    push_sub(1'b1, 24'h040404, 1'b0, 3'h0, 1'b0);
    play();
    check_val("validity at half", 32'h1, 32'(cuv_l));
    reg_write(RXO_ADDR_VDLY, 8'h00);
    push_sub(1'b0, 24'h050505, 1'b0, 3'h0, 1'b0);
    #150;
    check_bit("validity low now", 1'b0, v_out);
    push_sub(1'b1, 24'h060606, 1'b0, 3'h1, 1'b0);
    #150;
    check_bit("validity high now", 1'b1, v_out);
    repeat (3) push_frame(24'h000000, 24'h000000, 1'b0, 1'b0, 3'h0, 3'h0);
    check_bit("queue full", 1'b0, sub_ready);
    close_out();
  end
endmodule  // rxo_formatter_bench
